// *** verilog/pss_sequencer.sv ***
// functional state and regulator sequencing of the battery-monitor node
`timescale 1ns/100ps
`include "pss_regs.svh"
module pss_sequencer
   import pss_pkg::*;
#(
   parameter int T_SHUT_MS = `PSS_T_SHUT_MS,
   parameter int TICK_CYC  = `PSS_TICK_CYC
) (
   input  wire logic       ref_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       por_stby_i,
   input  wire logic       iso_edge_i,
   input  wire logic       spi_cs_i,
   input  wire logic       spi_clk_i,
   input  wire logic       fault_upper_input_i,
   input  wire logic       gpio7_i,
   input  wire logic       master_unit_i,
   input  wire logic       frame_ok_i,
   input  wire logic       sleep_request_cmd_i,
   input  wire logic       soft_reset_bit_i,
   input  wire logic       comm_activity_i,
   input  wire logic       wr_en_i,
   input  wire logic       wr_addr_field_i,
   input  wire logic       wr_link_field_i,
   input  wire logic       wr_other_i,
   input  wire logic [3:0] wr_node_address_i,
   input  wire logic       wr_upper_tx_en_i,
   input  wire logic [1:0] wr_link_rate_i,
   input  wire logic       wr_link_lock_i,
   input  wire logic [1:0] comm_timeout_select_i,
   input  wire logic       comm_timeout_dis_i,
   input  wire logic       pin7_wake_enable_i,
   input  wire logic       reference_regulator_enable_i,
   input  wire logic       sleep_bal_en_i,
   input  wire logic       balancing_active_i,
   input  wire logic       check_done_i,
   input  wire logic       main_gt_3v_i,
   input  wire logic       analog_ok_i,
   input  wire logic       comm_reg_ok_i,
   input  wire logic       main_osc_ok_i,
   output logic            main_regulator_o,
   output logic            analog_regulator_o,
   output logic            reference_regulator_o,
   output logic            bootstrap_o,
   output logic            comm_regulator_o,
   output logic            main_rst_n_o,
   output logic            main_clk_en_o,
   output logic            silent_bal_o,
   output logic            fault_mask_o,
   output logic            wr_accept_o,
   output logic            rd_block_o,
   output logic            fault_fwd_o,
   output logic [3:0]      node_address_o,
   output logic            upper_tx_en_o,
   output logic [1:0]      link_rate_o,
   output logic            link_lock_o,
   output logic [1:0]      comm_timeout_o,
   output pss_pkg::pss_state_t state_o
);
   import pss_pkg::*;

   // delays follow the tick, so a shortened tick keeps the ramp inside its timeouts
   localparam logic [23:0] CYC_REFERENCE_REGULATOR =
      24'((TICK_CYC * `PSS_T_REFERENCE_REGULATOR_DLY_US + `PSS_TICK_US - 1) / `PSS_TICK_US);
   localparam logic [23:0] CYC_BOOT  =
      24'((TICK_CYC * `PSS_T_BOOT_DLY_US + `PSS_TICK_US - 1) / `PSS_TICK_US);
   localparam logic [23:0] CYC_COMM_REGULATOR  =
      24'((TICK_CYC * `PSS_T_COMM_REGULATOR_DLY_US + `PSS_TICK_US - 1) / `PSS_TICK_US);
   localparam logic [23:0] CYC_OFF   =
      24'((TICK_CYC * `PSS_T_REG_OFF_US + `PSS_TICK_US - 1) / `PSS_TICK_US);

   // pins are asynchronous: two flops before any use
   logic [6:0] s1_q, s2_q;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q <= 7'h0;
         s2_q <= 7'h0;
      end else begin
         s1_q <= {por_stby_i, iso_edge_i, spi_cs_i, spi_clk_i, fault_upper_input_i,
                  gpio7_i, frame_ok_i};
         s2_q <= s1_q;
      end
   end
   logic por_s, iso_s, cs_s, sck_s, flt_s, g7_s, frm_s;
   assign {por_s, iso_s, cs_s, sck_s, flt_s, g7_s, frm_s} = s2_q;

   logic cs_p_q, sck_p_q, iso_p_q;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cs_p_q  <= 1'b1;
         sck_p_q <= 1'b0;
         iso_p_q <= 1'b0;
      end else begin
         cs_p_q  <= cs_s;
         sck_p_q <= sck_s;
         iso_p_q <= iso_s;
      end
   end
   // simple edge readout is enough for pre-wake
   logic pre_wake;
   assign pre_wake = (iso_s & ~iso_p_q) | (~cs_s & cs_p_q) | (sck_s & ~sck_p_q);

   // slow timebase standing in for the standby oscillator
   logic [23:0] div_q;
   logic        tick_q;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_q  <= 24'h0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (div_q == 24'(TICK_CYC - 1));
         div_q  <= (div_q == 24'(TICK_CYC - 1)) ? 24'h0 : div_q + 24'h1;
      end
   end

   pss_state_t st_q;
   pss_pwr_t   pw_q;
   logic       from_bal_q, first_pu_q, confirm_q, fault_wake_q, powering_dn_q;
   logic [23:0] ms_q;
   logic [23:0] idle_q;
   logic [23:0] comm_lim;
   pss_timer_if tif ();
   logic        t_start_q;
   logic [23:0] t_count_q;
   assign tif.start = t_start_q;
   assign tif.count = t_count_q;

   pss_timer u_dly (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .tick_i    (1'b1),
      .t         (tif)
   );

   always_comb begin
      case (comm_timeout_o)
         2'h0:    comm_lim = 24'(`PSS_T_COMM_00_MS);
         2'h1:    comm_lim = 24'(`PSS_T_COMM_01_MS);
         2'h2:    comm_lim = 24'(`PSS_T_COMM_10_MS);
         default: comm_lim = 24'(`PSS_T_COMM_11_MS);
      endcase
   end

   logic wake_src, go_sleep, comm_to, pu_to, pu_up, addr_cmd, sreset, g7_wake;
   assign g7_wake  = master_unit_i & pin7_wake_enable_i & g7_s;
   assign wake_src = pre_wake | flt_s | g7_wake;
   assign comm_to  = ~comm_timeout_dis_i & (idle_q >= comm_lim);
   assign go_sleep = sleep_request_cmd_i | comm_to;
   assign pu_up    = (pw_q == PSS_PW_ON) & comm_regulator_o & comm_reg_ok_i & main_osc_ok_i;
   // timeouts cover the ramp only; the wait for the confirming frame is bounded apart
   assign pu_to    = ~pu_up
                     & ((ms_q >= (first_pu_q ? 24'(`PSS_T_FIRST_PU_MS) : 24'(`PSS_T_PU_MS)))
                        | (~main_osc_ok_i & (ms_q >= 24'(`PSS_T_OSC_MS))));
   assign addr_cmd = wr_en_i & wr_addr_field_i & (st_q == PSS_INIT)
                     & (node_address_o == `PSS_ADDR_NONE);
   assign sreset   = soft_reset_bit_i & (st_q == PSS_NORMAL || st_q == PSS_INIT);

   // millisecond counter, restarted on every state change
   pss_state_t st_d;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) ms_q <= 24'h0;
      else if (st_d != st_q) ms_q <= 24'h0;
      else if (tick_q && ms_q != 24'hffffff) ms_q <= ms_q + 24'h1;
   end
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) idle_q <= 24'h0;
      else if (comm_activity_i || st_q != PSS_NORMAL && st_q != PSS_INIT) idle_q <= 24'h0;
      else if (tick_q && idle_q != 24'hffffff) idle_q <= idle_q + 24'h1;
   end

   always_comb begin
      st_d = st_q;
      case (st_q)
         PSS_RESET:  if (por_s) st_d = PSS_SLEEP;
         PSS_SLEEP: begin
            if (!powering_dn_q) begin
               if (wake_src) st_d = PSS_PWRUP;
               else if (!from_bal_q &&
                        ms_q >= 24'(`PSS_T_CYC_SLEEP_MS + `PSS_T_CYC_WUP_MS))
                  st_d = PSS_CHECK;
            end
         end
         PSS_PWRUP: begin
            if (pu_to) st_d = PSS_SLEEP;
            else if (pu_up) begin
               if (fault_wake_q) st_d = PSS_NORMAL;
               else if (confirm_q)
                  st_d = (node_address_o == `PSS_ADDR_NONE) ? PSS_INIT : PSS_NORMAL;
               else if (ms_q >= comm_lim) st_d = PSS_SLEEP;
            end
         end
         PSS_INIT: begin
            if (go_sleep) st_d = PSS_SLEEP;
            else if (addr_cmd && wr_node_address_i != `PSS_ADDR_NONE)
               st_d = PSS_NORMAL;
            else if (ms_q >= 24'(T_SHUT_MS)) st_d = PSS_SLEEP;
         end
         PSS_NORMAL: if (go_sleep) st_d = PSS_SLEEP;
         PSS_CHECK: begin
            if (flt_s) st_d = PSS_NORMAL;
            else if (check_done_i) st_d = PSS_SLEEP;
         end
         default: st_d = PSS_RESET;
      endcase
      if (!por_s) st_d = PSS_RESET;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) st_q <= PSS_RESET;
      else st_q <= st_d;
   end

   // sleep target: silent balancing flag, kept across wakes until normal is entered or balancing stops in sleep
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) from_bal_q <= 1'b0;
      else if (st_q == PSS_NORMAL && st_d == PSS_SLEEP)
         from_bal_q <= sleep_bal_en_i & balancing_active_i;
      else if (st_q == PSS_CHECK && st_d == PSS_SLEEP)
         from_bal_q <= from_bal_q & sleep_bal_en_i & balancing_active_i;
      else if (st_q == PSS_SLEEP && from_bal_q && !balancing_active_i)
         from_bal_q <= 1'b0;
      else if (st_d == PSS_NORMAL) from_bal_q <= 1'b0;
   end

   // wake confirmation: a consistent frame after pre-wake; its command is dropped
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         confirm_q    <= 1'b0;
         fault_wake_q <= 1'b0;
      end else if (st_q != PSS_PWRUP) begin
         confirm_q    <= g7_wake;
         fault_wake_q <= flt_s;
      end else begin
         if (frm_s) confirm_q <= 1'b1;
         if (flt_s) fault_wake_q <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) first_pu_q <= 1'b1;
      else if (st_q == PSS_PWRUP && st_d != PSS_PWRUP) first_pu_q <= 1'b0;
   end

   // regulator ordering; the off path waits the off delay before the main supply drops, except when a ramp delay expires on the edge the off path starts
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pw_q                  <= PSS_PW_OFF;
         main_regulator_o      <= 1'b0;
         analog_regulator_o    <= 1'b0;
         reference_regulator_o <= 1'b0;
         bootstrap_o           <= 1'b0;
         comm_regulator_o      <= 1'b0;
         powering_dn_q         <= 1'b0;
         t_start_q             <= 1'b0;
         t_count_q             <= 24'h0;
      end else begin
         t_start_q <= 1'b0;
         if (st_d == PSS_SLEEP || st_d == PSS_RESET) begin
            // a ramp cut short before PSS_PW_ON leaves only main (and perhaps analog) on; it still goes through the off delay
            if (comm_regulator_o || reference_regulator_o || bootstrap_o
                || (main_regulator_o && !powering_dn_q)) begin
               comm_regulator_o      <= 1'b0;
               reference_regulator_o <= 1'b0;
               bootstrap_o           <= 1'b0;
               powering_dn_q         <= 1'b1;
               t_start_q             <= 1'b1;
               t_count_q             <= CYC_OFF;
            end else if (powering_dn_q && tif.done) begin
               main_regulator_o   <= 1'b0;
               analog_regulator_o <= 1'b0;
               powering_dn_q      <= 1'b0;
            end
            pw_q <= PSS_PW_OFF;
         end else if (st_q == PSS_PWRUP || st_q == PSS_CHECK) begin
            case (pw_q)
               PSS_PW_OFF: begin
                  main_regulator_o <= 1'b1;
                  pw_q             <= PSS_PW_MAIN;
               end
               PSS_PW_MAIN: if (main_gt_3v_i) begin
                  analog_regulator_o <= 1'b1;
                  pw_q               <= PSS_PW_ANA;
               end
               PSS_PW_ANA: if (analog_ok_i) begin
                  t_start_q <= 1'b1;
                  t_count_q <= CYC_REFERENCE_REGULATOR;
                  pw_q      <= PSS_PW_REF;
               end
               PSS_PW_REF: if (tif.done) begin
                  reference_regulator_o <= reference_regulator_enable_i;
                  t_start_q             <= 1'b1;
                  t_count_q             <= CYC_BOOT;
                  pw_q                  <= PSS_PW_ON;
               end
               PSS_PW_ON: if (tif.done) begin
                  if (!bootstrap_o) begin
                     bootstrap_o <= 1'b1;
                     t_start_q   <= 1'b1;
                     t_count_q   <= CYC_COMM_REGULATOR - CYC_BOOT;
                  end else begin
                     comm_regulator_o <= 1'b1;
                  end
               end
               default: pw_q <= PSS_PW_OFF;
            endcase
         end
      end
   end

   // standby-held fields: address, link config; timeout select survives soft reset
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         node_address_o <= `PSS_ADDR_NONE;
         upper_tx_en_o  <= 1'b0;
         link_rate_o    <= 2'h0;
         link_lock_o    <= 1'b0;
         comm_timeout_o <= `PSS_COMM_TO_RST;
      end else if (st_q == PSS_RESET) begin
         node_address_o <= `PSS_ADDR_NONE;
         upper_tx_en_o  <= 1'b0;
         link_rate_o    <= 2'h0;
         link_lock_o    <= 1'b0;
         comm_timeout_o <= `PSS_COMM_TO_RST;
      end else if (sreset) begin
         node_address_o <= `PSS_ADDR_NONE;
         upper_tx_en_o  <= 1'b0;
         link_rate_o    <= 2'h0;
         link_lock_o    <= 1'b0;
      end else if (wr_en_i) begin
         if (addr_cmd) node_address_o <= wr_node_address_i;
         if (wr_link_field_i && !link_lock_o) begin
            upper_tx_en_o <= wr_upper_tx_en_i;
            link_rate_o   <= wr_link_rate_i;
         end
         if (wr_other_i && st_q == PSS_NORMAL) begin
            link_lock_o    <= link_lock_o | wr_link_lock_i;
            comm_timeout_o <= comm_timeout_select_i;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         main_rst_n_o  <= 1'b0;
         main_clk_en_o <= 1'b0;
         silent_bal_o  <= 1'b0;
         fault_mask_o  <= 1'b1;
         wr_accept_o   <= 1'b0;
         rd_block_o    <= 1'b1;
         fault_fwd_o   <= 1'b0;
         state_o       <= PSS_RESET;
      end else begin
         main_rst_n_o  <= (st_d == PSS_INIT || st_d == PSS_NORMAL
                           || st_d == PSS_CHECK);
         main_clk_en_o <= (st_d == PSS_INIT || st_d == PSS_NORMAL
                           || st_d == PSS_CHECK);
         silent_bal_o  <= (st_d == PSS_SLEEP) & from_bal_q;
         fault_mask_o  <= (st_d == PSS_INIT) & (node_address_o == `PSS_ADDR_NONE)
                          | (st_d != PSS_INIT && st_d != PSS_NORMAL
                             && st_d != PSS_CHECK);
         wr_accept_o   <= (st_d == PSS_NORMAL) | (st_d == PSS_INIT);
         rd_block_o    <= (st_d != PSS_NORMAL);
         fault_fwd_o   <= (st_d == PSS_NORMAL) & flt_s;
         state_o       <= st_d;
      end
   end
endmodule // pss_sequencer

// *** verilog/pss_regs.svh ***
// timing constants, reset values and encodings for the power state sequencer
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
`define PSS_CLK_HZ            10000000
// tick period of the slow sleep timebase in microseconds
`define PSS_TICK_US           1000
`define PSS_TICK_CYC          ((`PSS_CLK_HZ / 1000000) * `PSS_TICK_US)
// timeouts, all in milliseconds (slow ticks)
`define PSS_T_SHUT_MS         60000
`define PSS_T_CYC_SLEEP_MS    1000
`define PSS_T_CYC_WUP_MS      10
`define PSS_T_COMM_00_MS      32
`define PSS_T_COMM_01_MS      256
`define PSS_T_COMM_10_MS      1024
`define PSS_T_COMM_11_MS      2048
`define PSS_T_FIRST_PU_MS     4
`define PSS_T_PU_MS           2
`define PSS_T_OSC_MS          2
// power sequencing delays in microseconds
`define PSS_T_REFERENCE_REGULATOR_DLY_US    40
`define PSS_T_BOOT_DLY_US     100
`define PSS_T_COMM_REGULATOR_DLY_US     200
`define PSS_T_REG_OFF_US      500
`define PSS_US_CYC(us)        ((`PSS_CLK_HZ / 1000000) * (us))
`define PSS_ADDR_NONE         4'h0
`define PSS_COMM_TO_RST       2'h0
`endif

// *** verilog/pss_pkg.sv ***
// types of the power state sequencer
package pss_pkg;
   typedef enum logic [5:0] {
      PSS_RESET  = 6'h01,
      PSS_SLEEP  = 6'h02,
      PSS_PWRUP  = 6'h04,
      PSS_INIT   = 6'h08,
      PSS_NORMAL = 6'h10,
      PSS_CHECK  = 6'h20
   } pss_state_t;
   typedef enum logic [4:0] {
      PSS_PW_OFF  = 5'h01,
      PSS_PW_MAIN = 5'h02,
      PSS_PW_ANA  = 5'h04,
      PSS_PW_REF  = 5'h08,
      PSS_PW_ON   = 5'h10
   } pss_pwr_t;
endpackage

// *** verilog/pss_timer_if.sv ***
// handshake between the state machine and the delay timer
`timescale 1ns/100ps
interface pss_timer_if;
   logic        start;
   logic [23:0] count;
   logic        done;
   modport ctrl  (output start, output count, input done);
   modport timer (input start, input count, output done);
endinterface

// *** verilog/pss_timer.sv ***
// reloadable down counter, done is a one-cycle pulse on expiry
`timescale 1ns/100ps
module pss_timer (
   input  wire logic ref_clk_i,
   input  wire logic rst_n_i,
   input  wire logic tick_i,
   pss_timer_if.timer t
);
   logic [23:0] cnt_q;
   logic        run_q;
   logic        done_q;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q  <= 24'h0;
         run_q  <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (t.start) begin
            cnt_q <= t.count;
            run_q <= 1'b1;
         end else if (run_q && tick_i) begin
            if (cnt_q <= 24'h1) begin
               run_q  <= 1'b0;
               done_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q - 24'h1;
            end
         end
      end
   end

   assign t.done = done_q;
endmodule // pss_timer

// *** verif/pss_sequencer_sva.sv ***
// assertion checker for the power state sequencer
`timescale 1ns/100ps
module pss_sequencer_sva
   import pss_pkg::*;
(
   input wire logic       ref_clk_i,
   input wire logic       rst_n_i,
   input wire logic       por_stby_i,
   input wire logic       soft_reset_bit_i,
   input wire logic       main_regulator_o,
   input wire logic       reference_regulator_o,
   input wire logic       bootstrap_o,
   input wire logic       comm_regulator_o,
   input wire logic       main_rst_n_o,
   input wire logic       main_clk_en_o,
   input wire logic       fault_mask_o,
   input wire logic [3:0] node_address_o,
   input wire logic       upper_tx_en_o,
   input wire logic [1:0] link_rate_o,
   input wire logic       link_lock_o,
   input wire logic [1:0] comm_timeout_o,
   input wire pss_state_t state_o
);
   import pss_pkg::*;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_reset_to_sleep: assert property (state_o == PSS_RESET && por_stby_i
      |-> ##[1:5] state_o == PSS_SLEEP) else $error("sleep not reached");
   a_sleep_gated: assert property ((state_o == PSS_SLEEP)[*4]
      |-> !main_clk_en_o && !main_rst_n_o) else $error("main logic live in sleep");
   a_init_masked: assert property ((state_o == PSS_INIT)[*2] ##0 node_address_o == 4'h0
      |-> $past(fault_mask_o)) else $error("fault not masked");
   a_addr_locked: assert property (node_address_o != 4'h0 && !soft_reset_bit_i
      && state_o != PSS_RESET |=> $stable(node_address_o)) else $error("address changed");
   a_link_locked: assert property (link_lock_o && !soft_reset_bit_i
      && state_o != PSS_RESET |=> $stable(link_rate_o) && $stable(upper_tx_en_o))
      else $error("link field changed");
   a_timeout_kept: assert property (soft_reset_bit_i
      |=> $stable(comm_timeout_o)) else $error("timeout select lost");
   a_reg_order: assert property (comm_regulator_o || reference_regulator_o || bootstrap_o
      |-> main_regulator_o) else $error("regulator before main");
   a_down_together: assert property ($fell(comm_regulator_o)
      |-> !reference_regulator_o && !bootstrap_o) else $error("regulators not off together");
endmodule // pss_sequencer_sva
bind pss_sequencer pss_sequencer_sva u_sva (.ref_clk_i, .rst_n_i, .por_stby_i,
   .soft_reset_bit_i, .main_regulator_o, .reference_regulator_o, .bootstrap_o,
   .comm_regulator_o, .main_rst_n_o, .main_clk_en_o, .fault_mask_o, .node_address_o,
   .upper_tx_en_o, .link_rate_o, .link_lock_o, .comm_timeout_o, .state_o);

// *** verif/pss_host_model.sv ***
// host model: wakes the node over chip select, then sends a consistent frame
`timescale 1ns/100ps
module pss_host_model #(
   parameter int WAKE_WAIT = 4000
) (
   input  wire logic ref_clk_i,
   output logic      spi_cs_n_o,
   output logic      frame_ok_o
);
   initial begin
      spi_cs_n_o = 1'b1;
      frame_ok_o = 1'b0;
   end
   // frames sent before the power-up state is entered are dropped, so the host waits first
   task automatic frame();
      repeat (WAKE_WAIT) @(negedge ref_clk_i);
      frame_ok_o = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      frame_ok_o = 1'b0;
   endtask
   task automatic wake();
      @(negedge ref_clk_i);
      spi_cs_n_o = 1'b0;
      repeat (4) @(negedge ref_clk_i);
      spi_cs_n_o = 1'b1;
      frame();
   endtask
endmodule // pss_host_model

// *** verif/tb_pss_sequencer.sv ***
// self-checking bench for the power state sequencer
`timescale 1ns/100ps
module tb_pss_sequencer;
   import pss_pkg::*;
   logic ref_clk_i = 1'b0, rst_n_i = 1'b0, por_stby_i = 1'b1, iso_edge_i = 1'b0;
   logic spi_clk_i = 1'b0, fault_upper_input_i = 1'b0, gpio7_i = 1'b0, master_unit_i = 1'b1;
   logic sleep_request_cmd_i = 1'b0, soft_reset_bit_i = 1'b0, comm_activity_i = 1'b0;
   logic wr_en_i = 1'b0, wr_addr_field_i = 1'b0, wr_link_field_i = 1'b0, wr_other_i = 1'b0;
   logic wr_upper_tx_en_i = 1'b0, wr_link_lock_i = 1'b0, comm_timeout_dis_i = 1'b0;
   logic pin7_wake_enable_i = 1'b1, reference_regulator_enable_i = 1'b1, check_done_i = 1'b0;
   logic sleep_bal_en_i = 1'b0, balancing_active_i = 1'b0;
   logic [3:0] wr_node_address_i = 4'h0, node_address_o;
   logic [1:0] wr_link_rate_i = 2'h0, comm_timeout_select_i = 2'h0, link_rate_o, comm_timeout_o;
   wire  spi_cs_i, frame_ok_i, main_gt_3v_i, analog_ok_i, comm_reg_ok_i, main_osc_ok_i;
   logic main_regulator_o, analog_regulator_o, reference_regulator_o, bootstrap_o;
   logic comm_regulator_o, main_rst_n_o, main_clk_en_o, silent_bal_o, fault_mask_o;
   logic wr_accept_o, rd_block_o, fault_fwd_o, upper_tx_en_o, link_lock_o;
   pss_state_t state_o;
   int fail_count = 0, n_compared = 0, cyc = 0;
   // analog status follows its own enable, so the sequence never stalls
   assign main_gt_3v_i  = main_regulator_o;
   assign main_osc_ok_i = main_regulator_o;
   assign analog_ok_i   = analog_regulator_o;
   assign comm_reg_ok_i = comm_regulator_o;
   pss_sequencer #(.T_SHUT_MS(5), .TICK_CYC(20)) dut (.*);
   pss_host_model #(.WAKE_WAIT(100)) host (.ref_clk_i, .spi_cs_n_o(spi_cs_i),
                                           .frame_ok_o(frame_ok_i));
   always #50 ref_clk_i = ~ref_clk_i;
   task automatic test_done();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fail_count++;
         $display("mismatch at %0t: run hung", $time);
         test_done();
      end
   end
   task automatic wait_st(input pss_state_t s, input int lim);
      int n;
      n = 0;
      while (state_o !== s && n < lim) begin
         @(negedge ref_clk_i);
         n++;
      end
      n_compared++;
      if (state_o !== s) begin
         fail_count++;
         $display("mismatch at %0t: state %h not %h", $time, state_o, s);
      end
   endtask
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h not %h", $time, got, exp);
      end
   endtask
   // one data nibble feeds every write field; the selects pick what lands
   task automatic wr(input logic a, input logic l, input logic o, input logic [3:0] d);
      @(negedge ref_clk_i);
      {wr_en_i, wr_addr_field_i, wr_link_field_i, wr_other_i} = {1'b1, a, l, o};
      {wr_node_address_i, wr_link_rate_i, wr_upper_tx_en_i} = {d, d[1:0], d[2]};
      {wr_link_lock_i, comm_timeout_select_i} = {d[3], d[1:0]};
      @(negedge ref_clk_i);
      wr_en_i = 1'b0;
      repeat (3) @(negedge ref_clk_i);
   endtask
   initial begin
      repeat (3) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      wait_st(PSS_SLEEP, 10);
      repeat (4) @(negedge ref_clk_i);
      chk({2'h0, main_clk_en_o, main_rst_n_o}, 4'h0);
      host.wake();
      wait_st(PSS_INIT, 6000);
      chk({comm_regulator_o, bootstrap_o, reference_regulator_o, main_regulator_o}, 4'hf);
      chk({3'h0, fault_mask_o}, 4'h1);
      wait_st(PSS_SLEEP, 200);
      chk({1'b0, analog_regulator_o, comm_regulator_o, main_regulator_o}, 4'h5);
      repeat (300) @(negedge ref_clk_i);
      chk({2'h0, analog_regulator_o, main_regulator_o}, 4'h0);
      gpio7_i = 1'b1;
      wait_st(PSS_PWRUP, 20);
      gpio7_i = 1'b0;
      wait_st(PSS_INIT, 6000);
      wr(1'b0, 1'b1, 1'b1, 4'h6);
      chk({comm_timeout_o, link_rate_o}, 4'h2);
      chk({wr_accept_o, rd_block_o, 2'h0}, 4'hc);
      wr(1'b1, 1'b0, 1'b0, 4'h5);
      wait_st(PSS_NORMAL, 10);
      chk({wr_accept_o, rd_block_o, 2'h0}, 4'h8);
      wr(1'b1, 1'b0, 1'b0, 4'h9);
      chk(node_address_o, 4'h5);
      wr(1'b0, 1'b1, 1'b0, 4'h6);
      wr(1'b0, 1'b0, 1'b1, 4'h8);
      wr(1'b0, 1'b1, 1'b0, 4'h1);
      chk({link_lock_o, upper_tx_en_o, link_rate_o}, 4'he);
      {sleep_bal_en_i, balancing_active_i} = 2'h3;
      wait_st(PSS_SLEEP, 700);
      @(negedge ref_clk_i);
      chk({3'h0, silent_bal_o}, 4'h1);
      balancing_active_i = 1'b0;
      repeat (3) @(negedge ref_clk_i);
      chk({3'h0, silent_bal_o}, 4'h0);
      repeat (5100) @(negedge ref_clk_i);
      fault_upper_input_i = 1'b1;
      wait_st(PSS_NORMAL, 6000);
      chk({3'h0, fault_fwd_o}, 4'h1);
      fault_upper_input_i = 1'b0;
      wr(1'b0, 1'b0, 1'b1, 4'hb);
      @(negedge ref_clk_i) soft_reset_bit_i = 1'b1;
      @(negedge ref_clk_i) soft_reset_bit_i = 1'b0;
      repeat (3) @(negedge ref_clk_i);
      chk(node_address_o, 4'h0);
      chk({2'h0, comm_timeout_o}, 4'h3);
      wait_st(PSS_NORMAL, 0);
      @(negedge ref_clk_i) sleep_request_cmd_i = 1'b1;
      @(negedge ref_clk_i) sleep_request_cmd_i = 1'b0;
      wait_st(PSS_SLEEP, 10);
      wait_st(PSS_CHECK, 20300);
      @(negedge ref_clk_i) check_done_i = 1'b1;
      @(negedge ref_clk_i) check_done_i = 1'b0;
      wait_st(PSS_SLEEP, 10);
      test_done();
   end
endmodule // tb_pss_sequencer
